// ===== hdl/bad_pkg.sv
package bad_pkg;
    localparam logic [7:0] OPC_DADJ = 8'hd4;
    localparam logic [7:0] OPC_DEC_ACC = 8'h14;
    localparam logic [7:0] OPC_DEC_DIR = 8'h15;
    localparam logic [6:0] OPC_DEC_IND = 7'h0b;
    localparam logic [4:0] OPC_DEC_REG = 5'h03;
    localparam logic [7:0] OPC_DIVU = 8'h84;
    localparam logic [4:0] OPC_DBNZ_REG = 5'h1b;
    localparam logic [7:0] OPC_DBNZ_DIR = 8'hd5;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam int DIV_STEPS = 8;
    localparam logic [15:0] PC_RESET = 16'h0000;

    typedef enum logic [2:0] {
        BAD_TGT_NONE,
        BAD_TGT_ACC,
        BAD_TGT_REG,
        BAD_TGT_DIR,
        BAD_TGT_IND
    } bad_tgt_t;

    // One decoded instruction handed in by the fetch/decode stage
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [7:0] operand;
        logic [7:0] rel;
        logic [15:0] next_pc;
    } bad_instr_t;

    // Architectural state seen by the datapath
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] divisor;
        logic carry;
        logic half_carry;
        logic overflow;
        logic [7:0] mem_rd;
        logic port_sel;
        logic [7:0] port_latch;
    } bad_state_t;

    // Write-back produced by the datapath
    typedef struct packed {
        logic acc_we;
        logic [7:0] acc;
        logic div_we;
        logic [7:0] divisor;
        logic carry_we;
        logic carry;
        logic ov_we;
        logic overflow;
        logic mem_we;
        bad_tgt_t mem_tgt;
        logic [7:0] mem_addr;
        logic [7:0] mem_data;
        logic pc_we;
        logic [15:0] pc;
        logic done;
    } bad_wb_t;
endpackage : bad_pkg

// ===== hdl/bad_core.sv
`timescale 1ns/1ps
module bad_core (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire bad_pkg::bad_instr_t instr,
    input wire bad_pkg::bad_state_t state,
    output bad_pkg::bad_wb_t wb
);
    import bad_pkg::*;

    typedef enum {BAD_IDLE, BAD_DIV, BAD_BR2} bad_phase_t;

    bad_phase_t phase;
    logic [7:0] div_q;
    logic [7:0] div_r;
    logic [7:0] div_d;
    logic [3:0] div_cnt;
    logic [15:0] br_target;
    logic br_take;
    bad_wb_t next_wb;

    function automatic logic [7:0] dec8(input logic [7:0] v);
        return v - 8'h01;
    endfunction : dec8

    function automatic logic [7:0] pick_src(input bad_state_t s);
        return s.port_sel ? s.port_latch : s.mem_rd;
    endfunction : pick_src

    logic [8:0] da_lo;
    logic [8:0] da_hi;
    logic da_c1;
    logic [7:0] dec_val;
    logic [8:0] rem_try;

    always_comb begin
        // low nibble fix, half-carry from status word
        if (state.acc[3:0] > BCD_MAX || state.half_carry) begin
            da_lo = {1'b0, state.acc} + {5'h00, BCD_FIX};
        end else begin
            da_lo = {1'b0, state.acc};
        end
        da_c1 = state.carry | da_lo[8];
        if (da_c1 || da_lo[7:4] > BCD_MAX) begin
            da_hi = {1'b0, da_lo[7:0]} + {1'b0, BCD_FIX, 4'h0};
        end else begin
            da_hi = {1'b0, da_lo[7:0]};
        end
        dec_val = dec8(pick_src(state));
        rem_try = {div_r, div_q[7]} - {1'b0, div_d};
    end

    always_comb begin
        next_wb = '0;
        if (phase == BAD_IDLE && instr.valid) begin
            if (instr.opcode == OPC_DADJ) begin
                // decimal adjust, single cycle, no overflow write
                next_wb.acc_we = 1'b1;
                next_wb.acc = da_hi[7:0];
                next_wb.carry_we = 1'b1;
                next_wb.carry = da_c1 | da_hi[8];
                next_wb.done = 1'b1;
            end else if (instr.opcode == OPC_DEC_ACC) begin
                next_wb.acc_we = 1'b1;
                next_wb.acc = dec8(state.acc);
                next_wb.done = 1'b1;
            end else if (instr.opcode[7:3] == OPC_DEC_REG || instr.opcode == OPC_DEC_DIR
                         || instr.opcode[7:1] == OPC_DEC_IND) begin
                next_wb.mem_we = 1'b1;
                next_wb.mem_tgt = instr.opcode[3] ? BAD_TGT_REG
                                : (instr.opcode[1] ? BAD_TGT_IND : BAD_TGT_DIR);
                next_wb.mem_addr = instr.operand;
                next_wb.mem_data = dec_val;
                next_wb.done = 1'b1;
            end else if (instr.opcode == OPC_DIVU && state.divisor == 8'h00) begin
                next_wb.carry_we = 1'b1;
                next_wb.ov_we = 1'b1;
                next_wb.overflow = 1'b1;
                next_wb.done = 1'b1;
            end
        end else if (phase == BAD_DIV && div_cnt == 4'h0) begin
            next_wb.acc_we = 1'b1;
            next_wb.acc = div_q;
            next_wb.div_we = 1'b1;
            next_wb.divisor = div_r;
            next_wb.carry_we = 1'b1;
            next_wb.ov_we = 1'b1;
            next_wb.done = 1'b1;
        end else if (phase == BAD_BR2) begin
            next_wb.pc_we = 1'b1;
            next_wb.pc = br_take ? br_target : instr.next_pc;
            next_wb.done = 1'b1;
        end
        if (phase == BAD_IDLE && instr.valid
            && (instr.opcode[7:3] == OPC_DBNZ_REG || instr.opcode == OPC_DBNZ_DIR)) begin
            next_wb.mem_we = 1'b1;
            next_wb.mem_tgt = instr.opcode[3] ? BAD_TGT_REG : BAD_TGT_DIR;
            next_wb.mem_addr = instr.operand;
            next_wb.mem_data = dec_val;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= BAD_IDLE;
        end else begin
            case (phase)
                BAD_IDLE: begin
                    if (instr.valid && instr.opcode == OPC_DIVU && state.divisor != 8'h00) begin
                        phase <= BAD_DIV;
                    end else if (instr.valid
                                 && (instr.opcode[7:3] == OPC_DBNZ_REG || instr.opcode == OPC_DBNZ_DIR)) begin
                        phase <= BAD_BR2;
                    end
                end
                BAD_DIV: begin
                    if (div_cnt == 4'h0) begin
                        phase <= BAD_IDLE;
                    end
                end
                default: begin
                    phase <= BAD_IDLE;
                end
            endcase
        end
    end

    // Restoring divider: one quotient bit per cycle keeps the array small
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 8'h00;
            div_r <= 8'h00;
            div_d <= 8'h00;
            div_cnt <= 4'h0;
        end else if (phase == BAD_IDLE) begin
            div_q <= state.acc;
            div_r <= 8'h00;
            div_d <= state.divisor;
            div_cnt <= 4'(DIV_STEPS);
        end else if (phase == BAD_DIV && div_cnt != 4'h0) begin
            if (!rem_try[8]) begin
                div_r <= rem_try[7:0];
            end else begin
                div_r <= {div_r[6:0], div_q[7]};
            end
            div_q <= {div_q[6:0], ~rem_try[8]};
            div_cnt <= div_cnt - 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            br_target <= PC_RESET;
            br_take <= 1'b0;
        end else if (phase == BAD_IDLE) begin
            br_target <= instr.next_pc + {{8{instr.rel[7]}}, instr.rel};
            br_take <= (dec_val != 8'h00);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb <= '0;
        end else begin
            wb <= next_wb;
        end
    end

    a_dadj_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DADJ) |=> (wb.acc_we && wb.done))
        else $error("decimal adjust did not finish in one cycle");
    a_dadj_no_ov: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DADJ) |=> !wb.ov_we)
        else $error("decimal adjust touched overflow");
    a_dadj_carry_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DADJ && state.carry) |=> wb.carry)
        else $error("decimal adjust cleared carry");
    a_dadj_low_fix: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DADJ && !state.half_carry
         && state.acc[3:0] <= 4'h9) |=> wb.acc[3:0] == $past(state.acc[3:0]))
        else $error("low nibble changed without need");
    a_dadj_high_fix: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DADJ && state.carry
         && state.acc == 8'h00 && !state.half_carry) |=> wb.acc == 8'h60)
        else $error("high nibble not corrected on carry");
    a_dec_acc_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DEC_ACC) |=>
        (wb.acc == $past(state.acc) - 8'h01 && !wb.carry_we && !wb.ov_we))
        else $error("accumulator decrement wrong");
    a_dec_port_latch: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DEC_DIR && state.port_sel) |=>
        wb.mem_data == $past(state.port_latch) - 8'h01)
        else $error("port decrement not from latch");
    a_dec_modes: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode[7:1] == OPC_DEC_IND) |=>
        (wb.mem_we && wb.mem_tgt == BAD_TGT_IND))
        else $error("indirect decrement not written");
    a_div_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DIVU && state.divisor == 8'h00) |=>
        (wb.overflow && wb.ov_we && wb.carry_we && !wb.carry))
        else $error("divide by zero flags wrong");
    // Dividend is taken back from the edge after the take edge, where it is still held, nine edges before the check
    a_div_result: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_DIV && div_cnt == 4'h0) |=>
        (16'(wb.acc) * 16'(div_d) + 16'(wb.divisor) == 16'($past(state.acc, 9)) && wb.divisor < div_d
         && wb.carry_we && wb.ov_we && !wb.carry && !wb.overflow && wb.div_we && wb.acc_we))
        else $error("divide result flags wrong");
    a_div_busy_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_DIV && div_cnt != 4'h0) |=> (!wb.done && !wb.acc_we && !wb.div_we))
        else $error("divide wrote back early");
    a_div_done_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DIVU && state.divisor != 8'h00) |=>
        ##[1:9] wb.done)
        else $error("divide never completed");
    a_dbnz_two_cyc: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DBNZ_DIR) |=>
        (!wb.done && wb.mem_we) ##1 (wb.done && wb.pc_we))
        else $error("decrement-branch not two cycles");
    a_dbnz_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && (instr.opcode[7:3] == OPC_DBNZ_REG || instr.opcode == OPC_DBNZ_DIR)
         && dec_val == 8'h00) |=> ##1 (wb.pc_we && wb.pc == $past(instr.next_pc, 2)))
        else $error("branch taken on zero result");
    a_dbnz_target: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && (instr.opcode[7:3] == OPC_DBNZ_REG || instr.opcode == OPC_DBNZ_DIR)
         && dec_val != 8'h00) |=>
        ##1 (wb.pc_we && wb.pc == $past(instr.next_pc, 2) + 16'($signed($past(instr.rel, 2)))))
        else $error("branch target wrong");
    a_dbnz_mem_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && (instr.opcode[7:3] == OPC_DBNZ_REG || instr.opcode == OPC_DBNZ_DIR)) |=>
        (wb.mem_we && wb.mem_addr == $past(instr.operand) && !wb.carry_we && !wb.ov_we
         && wb.mem_data == $past(state.port_sel ? state.port_latch : state.mem_rd) - 8'h01)
        ##1 (!wb.carry_we && !wb.ov_we && !wb.mem_we))
        else $error("decrement-branch write wrong");
    a_dec_no_flags: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && (instr.opcode[7:3] == OPC_DEC_REG || instr.opcode == OPC_DEC_DIR
         || instr.opcode[7:1] == OPC_DEC_IND)) |=>
        (wb.mem_we && wb.mem_addr == $past(instr.operand) && !wb.carry_we && !wb.ov_we && !wb.acc_we
         && wb.mem_data == $past(state.port_sel ? state.port_latch : state.mem_rd) - 8'h01))
        else $error("memory decrement wrong");
    // Low digit over nine with a small high digit: only the low fix applies
    a_dadj_low_add: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (phase == BAD_IDLE && instr.valid && instr.opcode == OPC_DADJ && !state.carry
         && state.acc[3:0] > 4'h9 && state.acc[7:4] < 4'h9) |=> wb.acc == $past(state.acc) + 8'h06)
        else $error("low nibble fix missing");

    c_dadj: cover property (@(posedge ref_clk) disable iff (!rst_b)
        instr.valid && instr.opcode == OPC_DADJ && state.acc == 8'hbe);
    c_div: cover property (@(posedge ref_clk) disable iff (!rst_b) phase == BAD_DIV && div_cnt == 4'h0);
    c_dbnz_taken: cover property (@(posedge ref_clk) disable iff (!rst_b) phase == BAD_BR2 && br_take);
    c_dec_port: cover property (@(posedge ref_clk) disable iff (!rst_b)
        instr.valid && instr.opcode == OPC_DEC_DIR && state.port_sel);
endmodule : bad_core

// ===== tb/bad_fetch_model.sv
`timescale 1ns/1ps
// Stand-in for fetch/decode: issues one instruction, valid for one cycle, and holds its other fields until the core reports done
module bad_fetch_model
    import bad_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire bad_pkg::bad_instr_t cmd_instr,
    input wire bad_pkg::bad_state_t cmd_state,
    input wire bad_pkg::bad_wb_t wb,
    output bad_pkg::bad_instr_t instr,
    output bad_pkg::bad_state_t state
);
    logic held;

    // Launch on the falling edge so the core samples settled values
    always_ff @(negedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            instr <= '0;
            state <= '0;
            held <= 1'b0;
        end else if (start) begin
            instr <= cmd_instr;
            state <= cmd_state;
            held <= 1'b1;
        end else if (held && !wb.done) begin
            instr.valid <= 1'b0;
        end else begin
            // Released fields keep moving so a stale value cannot pass for a held one
            instr <= ~instr;
            instr.valid <= 1'b0;
            state <= ~state;
            held <= 1'b0;
        end
    end
endmodule : bad_fetch_model

// ===== tb/tb_bad_core.sv
`timescale 1ns/1ps
module tb_bad_core;
    import bad_pkg::*;

    typedef struct {
        logic [7:0] op, opd, rel;
        logic [15:0] npc;
        logic [7:0] a, b;
        logic c, ac, ov;
        logic [7:0] rd;
        logic ps;
        logic [7:0] pl, ea, eb;
        logic ec, eov;
        logic [7:0] em;
        bad_tgt_t et;
        logic [15:0] epc;
        int cyc;
    } bad_row_t;

    logic ref_clk = 1'b0;
    logic rst_b;
    logic start;
    bad_instr_t cmd_instr;
    bad_state_t cmd_state;
    bad_instr_t instr;
    bad_state_t state;
    bad_wb_t wb;
    int num_errors;
    int tests_run;
    bad_row_t rows[17];

    always #5 ref_clk = ~ref_clk;

    bad_core bad_core_inst (.ref_clk(ref_clk), .rst_b(rst_b), .instr(instr), .state(state), .wb(wb));

    bad_fetch_model bad_fetch_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .start(start), .cmd_instr(cmd_instr),
        .cmd_state(cmd_state), .wb(wb), .instr(instr), .state(state));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("Counts: tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic launch(input bad_row_t r);
        @(posedge ref_clk);
        cmd_instr <= '{1'b1, r.op, r.opd, r.rel, r.npc};
        cmd_state <= '{r.a, r.b, r.c, r.ac, r.ov, r.rd, r.ps, r.pl};
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
    endtask : launch

    // Unwritten fields keep their old value, as the far side would see them
    task automatic run(input bad_row_t r);
        logic [7:0] ga, gb, gm, gadr;
        logic gc, gov;
        bad_tgt_t gt;
        logic [15:0] gpc;
        int n;
        int lim;
        ga = r.a;
        gb = r.b;
        gc = r.c;
        gov = r.ov;
        gm = 8'h00;
        gadr = 8'h00;
        gt = BAD_TGT_NONE;
        gpc = 16'h0000;
        n = 0;
        lim = (r.cyc == 0) ? 4 : 12;
        launch(r);
        for (int i = 1; i <= lim && n == 0; i++) begin
            @(negedge ref_clk);
            if (wb.acc_we === 1'b1) ga = wb.acc;
            if (wb.div_we === 1'b1) gb = wb.divisor;
            if (wb.carry_we === 1'b1) gc = wb.carry;
            if (wb.ov_we === 1'b1) gov = wb.overflow;
            if (wb.mem_we === 1'b1) begin
                gm = wb.mem_data;
                gadr = wb.mem_addr;
                gt = wb.mem_tgt;
            end
            if (wb.pc_we === 1'b1) gpc = wb.pc;
            if (wb.done === 1'b1) n = i;
        end
        check(16'(ga), 16'(r.ea));
        check(16'(gb), 16'(r.eb));
        check(16'(gc), 16'(r.ec));
        check(16'(gov), 16'(r.eov));
        check(16'(gm), 16'(r.em));
        check(16'(gt), 16'(r.et));
        check(16'(gadr), 16'(r.opd));
        check(gpc, r.epc);
        check(16'(n), 16'(r.cyc));
        if (n == 0 && r.cyc != 0) end_sim();
    endtask : run

    initial begin
        rst_b = 1'b0;
        start = 1'b0;
        cmd_instr = '0;
        cmd_state = '0;
        num_errors = 0;
        tests_run = 0;
        rows = '{
            '{8'hd4, 8'h00, 8'h00, 16'h0000, 8'hbe, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h24, 8'h00, 1'h1, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'hd4, 8'h00, 8'h00, 16'h0000, 8'hc9, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h29, 8'h00, 1'h1, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'hd4, 8'h00, 8'h00, 16'h0000, 8'h12, 8'h00, 1'h1, 1'h1, 1'h1, 8'h00, 1'h0, 8'h00,
              8'h78, 8'h00, 1'h1, 1'h1, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'hd4, 8'h00, 8'h00, 16'h0000, 8'h9a, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h00, 8'h00, 1'h1, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'h14, 8'h00, 8'h00, 16'h0000, 8'h00, 8'h00, 1'h1, 1'h0, 1'h1, 8'h00, 1'h0, 8'h00,
              8'hff, 8'h00, 1'h1, 1'h1, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'h1d, 8'h05, 8'h00, 16'h0000, 8'h33, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h33, 8'h00, 1'h0, 1'h0, 8'hff, BAD_TGT_REG, 16'h0000, 1},
            '{8'h15, 8'h90, 8'h00, 16'h0000, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 8'h77, 1'h1, 8'h40,
              8'h00, 8'h00, 1'h0, 1'h0, 8'h3f, BAD_TGT_DIR, 16'h0000, 1},
            '{8'h17, 8'h7f, 8'h00, 16'h0000, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 8'h80, 1'h0, 8'h00,
              8'h00, 8'h00, 1'h0, 1'h0, 8'h7f, BAD_TGT_IND, 16'h0000, 1},
            '{8'h84, 8'h00, 8'h00, 16'h0000, 8'hfb, 8'h12, 1'h1, 1'h0, 1'h1, 8'h00, 1'h0, 8'h00,
              8'h0d, 8'h11, 1'h0, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 10},
            '{8'h84, 8'h00, 8'h00, 16'h0000, 8'h55, 8'h00, 1'h1, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h55, 8'h00, 1'h0, 1'h1, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'hd5, 8'h90, 8'h10, 16'h0033, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 8'h09, 1'h1, 8'h01,
              8'h00, 8'h00, 1'h0, 1'h0, 8'h00, BAD_TGT_DIR, 16'h0033, 2},
            '{8'hda, 8'h02, 8'hf0, 16'h0102, 8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 8'h70, 1'h0, 8'h00,
              8'h00, 8'h00, 1'h0, 1'h0, 8'h6f, BAD_TGT_REG, 16'h00f2, 2},
            '{8'hd8, 8'h00, 8'h05, 16'h0200, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h00, 8'h00, 1'h1, 1'h0, 8'hff, BAD_TGT_REG, 16'h0205, 2},
            '{8'ha5, 8'h00, 8'h00, 16'h0000, 8'h11, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h11, 8'h00, 1'h0, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 0},
            '{8'hd4, 8'h00, 8'h00, 16'h0000, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h60, 8'h00, 1'h1, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'hd4, 8'h00, 8'h00, 16'h0000, 8'hfa, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h60, 8'h00, 1'h1, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 1},
            '{8'hd4, 8'h00, 8'h00, 16'h0000, 8'h3c, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00,
              8'h42, 8'h00, 1'h0, 1'h0, 8'h00, BAD_TGT_NONE, 16'h0000, 1}
        };
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        check(16'(wb === '0), 16'h0001);
        foreach (rows[k]) run(rows[k]);
        // Reset in mid-divide must leave no stray write-back
        launch(rows[8]);
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b0;
        #1 check(16'(wb === '0), 16'h0001);
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (12) @(negedge ref_clk) check(16'(wb === '0), 16'h0001);
        run(rows[0]);
        end_sim();
    end
endmodule : tb_bad_core
